// File: design/sstm_map.vh
// Register offsets, field positions, reset values and timing for the tail-marker shifter.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SSTM_MAP_VH
`define SSTM_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SSTM_ADDR_W 3
`define SSTM_OFS_CTRL 3'h0
`define SSTM_OFS_STAT 3'h1
`define SSTM_OFS_DLO 3'h2
`define SSTM_OFS_DHI 3'h3
`define SSTM_OFS_IREQ 3'h4
`define SSTM_OFS_IEN 3'h5
`define SSTM_OFS_PFUN 3'h6
`define SSTM_OFS_POUT 3'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SSTM_CTRL_MODE_HI 7
`define SSTM_CTRL_MODE_LO 6
`define SSTM_CTRL_TAIL_EN 5
`define SSTM_CTRL_TAIL_TYPE 4
`define SSTM_CTRL_EXT_CLK 3
`define SSTM_CTRL_RATE_HI 2
`define SSTM_STAT_RSVD_ONE 7
`define SSTM_STAT_OUT_LVL 6
`define SSTM_STAT_OVERRUN 5
`define SSTM_STAT_TAIL_SEND 1
`define SSTM_STAT_START 0
`define SSTM_IREQ_DONE 0
`define SSTM_IEN_DONE 0
`define SSTM_PFUN_SO 0
`define SSTM_PFUN_SI 1
`define SSTM_PFUN_SCK 2
`define SSTM_POUT_OD 0

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SSTM_CTRL_RST 8'h00
`define SSTM_BYTE_ZERO 8'h00
`define SSTM_WORD_ZERO 16'h0000
`define SSTM_BITS_8 5'h08
`define SSTM_BITS_16 5'h10
`define SSTM_CNT_ZERO 5'h00
`define SSTM_CNT_ONE 5'h01
`define SSTM_TAIL_HOLD_HT 3'h2
`define SSTM_TAIL_LATCH_HT 3'h4
`define SSTM_TAIL_ZERO 3'h0
`define SSTM_TAIL_ONE 3'h1

// ----------------------------------------------------------------------
// Prescaler half periods less one, in system clocks, for divisors 1024 down to 2
// ----------------------------------------------------------------------
`define SSTM_PS_W 9
`define SSTM_PS_ZERO 9'h000
`define SSTM_PS_ONE 9'h001
`define SSTM_HALF_0 9'h1ff
`define SSTM_HALF_1 9'h07f
`define SSTM_HALF_2 9'h01f
`define SSTM_HALF_3 9'h00f
`define SSTM_HALF_4 9'h007
`define SSTM_HALF_5 9'h003
`define SSTM_HALF_6 9'h001
`define SSTM_HALF_7 9'h000

`endif

// File: design/sstm_prescale.v
// Half-period tick generator for the internal transfer clock.
// Assumes restart is pulsed when a transfer starts so the first edge has full length.
`timescale 1ns/1ps
`include "sstm_map.vh"

module sstm_prescale (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  input wire ce_i,
  // Control
  input wire restart_i,
  input wire [2:0] rate_sel_i,
  // Tick
  output reg half_tick_o
);

  reg [`SSTM_PS_W-1:0] cnt_q;
  reg [`SSTM_PS_W-1:0] limit;

  always @*
  begin
    case (rate_sel_i)
      3'h0: limit = `SSTM_HALF_0;
      3'h1: limit = `SSTM_HALF_1;
      3'h2: limit = `SSTM_HALF_2;
      3'h3: limit = `SSTM_HALF_3;
      3'h4: limit = `SSTM_HALF_4;
      3'h5: limit = `SSTM_HALF_5;
      3'h6: limit = `SSTM_HALF_6;
      default: limit = `SSTM_HALF_7;
    endcase
  end

  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q <= `SSTM_PS_ZERO;
      half_tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (restart_i || cnt_q >= limit)
      begin
        cnt_q <= `SSTM_PS_ZERO;
        half_tick_o <= !restart_i;
      end
      else
      begin
        cnt_q <= cnt_q + `SSTM_PS_ONE;
        half_tick_o <= 1'b0;
      end
    end
  end

endmodule // sstm_prescale

// File: design/sstm_edge.v
// Edge detector for the external serial clock pin.
// Assumes the pin is already synchronous to the system clock.
`timescale 1ns/1ps

module sstm_edge (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  input wire ce_i,
  // Pin level
  input wire level_i,
  // Edge pulses
  output wire rise_o,
  output wire fall_o
);

  reg prev_q;

  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      prev_q <= 1'b1;
    else if (ce_i)
      prev_q <= level_i;
  end

  assign rise_o = ce_i && level_i && !prev_q;
  assign fall_o = ce_i && !level_i && prev_q;

endmodule // sstm_edge

// File: design/sstm_core.v
// Synchronous serial shifter with optional end marker, registers on a plain port.
// Assumes pins are synchronous to sys_clk_i and the host keeps its setup order.
//
// Behaviour
// - Plain word mode: mode high bit 0, low bit picks 8/16, marker off.
// - Control write with marker disabled resets internal transfer state.
// - 8-bit uses low byte only; 16-bit uses high and low bytes.
// - Setting start begins a transfer, shifting transmit data out.
// - Receive setup shifts in samples from the serial input pin.
// - Completed word sets the transfer-done request bit.
// - Combined mode shifts both ways; done raised after both finish.
// - Internal clock driven with data, stops after completion until restart.
// - After transmission in plain word mode the output keeps the last bit level.
// - External clock edges shift transmit and receive data.
// - External clock after completion moves nothing, sets overrun.
// - While idle, writing out level drives the output pin.
// - Tail bus mode: marker on, mode high bit 0, low bit picks width.
// - Tail bus mode sends an end marker after every word.
// - Host selects hold or latch marker; device emits selected waveform.
// - Marker timing unit is the internal prescaler half period, even with the external clock selected.
// - Word done in tail mode: clear start, set done, send marker flagged.
// - Interrupt output follows done request only while enabled.
// - Transmit bit changes on falling edge; receive sampled on rising edge.
// - Start reads one while busy or waiting; clears when done.
// - Overrun clears only by writing zero after reading it set.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sstm_map.vh"

module sstm_core (
  // Clock, reset and enable
  input wire sys_clk_i,
  input wire rstn_i,
  input wire ce_i,
  // Register port
  input wire [`SSTM_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire we_i,
  input wire re_i,
  output reg [7:0] rdata_o,
  // Serial pins
  output reg so_o,
  output reg so_oe_o,
  input wire si_i,
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe_o,
  // Interrupt request
  output reg irq_o
);

  // ----------------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_TAIL = 2'd3;

  reg [1:0] state_q;
  reg [7:0] ctrl_q;
  reg [15:0] shift_q;
  reg [4:0] bit_cnt_q;
  reg [2:0] tail_cnt_q;
  reg start_q;
  reg overrun_q;
  reg ovr_seen_q;
  reg done_req_q;
  reg done_en_q;
  reg [2:0] pfun_q;
  reg open_drain_q;
  reg so_q;
  reg sck_q;

  wire wr_ctrl = we_i && addr_i == `SSTM_OFS_CTRL;
  wire wr_stat = we_i && addr_i == `SSTM_OFS_STAT;
  wire wr_dlo = we_i && addr_i == `SSTM_OFS_DLO;
  wire wr_dhi = we_i && addr_i == `SSTM_OFS_DHI;
  wire wr_ireq = we_i && addr_i == `SSTM_OFS_IREQ;
  wire rd_stat = re_i && addr_i == `SSTM_OFS_STAT;

  wire word16 = ctrl_q[`SSTM_CTRL_MODE_LO];
  wire tail_en = ctrl_q[`SSTM_CTRL_TAIL_EN];
  wire ext_clk = ctrl_q[`SSTM_CTRL_EXT_CLK];
  wire rx_en = pfun_q[`SSTM_PFUN_SI];
  wire [4:0] n_bits = word16 ? `SSTM_BITS_16 : `SSTM_BITS_8;
  wire idle = state_q == ST_IDLE;
  wire start_req = wr_stat && wdata_i[`SSTM_STAT_START] && idle;
  wire ctrl_reset = wr_ctrl && !wdata_i[`SSTM_CTRL_TAIL_EN];

  // ----------------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------------
  wire half_tick;
  wire ext_rise;
  wire ext_fall;

  sstm_prescale u_prescale (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .restart_i(start_req),
    .rate_sel_i(ctrl_q[`SSTM_CTRL_RATE_HI:0]),
    .half_tick_o(half_tick)
  );

  sstm_edge u_edge (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .level_i(sck_i),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  // Internal clock: a tick with the clock high is a falling edge, low is rising.
  wire int_fall = !ext_clk && half_tick && sck_q;
  wire int_rise = !ext_clk && half_tick && !sck_q;
  wire do_fall = ext_clk ? ext_fall : int_fall;
  wire do_rise = ext_clk ? ext_rise : int_rise;

  // Receive bit enters at the top of the active word width.
  wire rx_bit = rx_en ? si_i : 1'b0;
  wire [15:0] shift_next = word16 ? {rx_bit, shift_q[15:1]} :
    {shift_q[15:8], rx_bit, shift_q[7:1]};
  wire last_bit = bit_cnt_q == n_bits - `SSTM_CNT_ONE;
  wire word_done = state_q == ST_DATA && do_rise && last_bit;
  wire [2:0] tail_len = ctrl_q[`SSTM_CTRL_TAIL_TYPE] ? `SSTM_TAIL_LATCH_HT : `SSTM_TAIL_HOLD_HT;

  // ----------------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= `SSTM_CNT_ZERO;
      tail_cnt_q <= `SSTM_TAIL_ZERO;
      start_q <= 1'b0;
      so_q <= 1'b0;
      sck_q <= 1'b1;
      shift_q <= `SSTM_WORD_ZERO;
    end
    else if (ce_i)
    begin
      if (wr_dlo && idle)
        shift_q[7:0] <= wdata_i;
      if (wr_dhi && idle)
        shift_q[15:8] <= wdata_i;
      if (ctrl_reset)
      begin
        state_q <= ST_IDLE;
        bit_cnt_q <= `SSTM_CNT_ZERO;
        tail_cnt_q <= `SSTM_TAIL_ZERO;
        start_q <= 1'b0;
        sck_q <= 1'b1;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            if (wr_stat)
              so_q <= wdata_i[`SSTM_STAT_OUT_LVL];
            if (start_req)
            begin
              start_q <= 1'b1;
              bit_cnt_q <= `SSTM_CNT_ZERO;
              sck_q <= 1'b1;
              state_q <= ext_clk ? ST_WAIT : ST_DATA;
            end
          end
          ST_WAIT:
          begin
            // Busy flag stays set while waiting for the master's first falling edge.
            if (ext_fall)
            begin
              so_q <= shift_q[0];
              state_q <= ST_DATA;
            end
          end
          ST_DATA:
          begin
            if (do_fall)
            begin
              so_q <= shift_q[0];
              sck_q <= 1'b0;
            end
            else if (do_rise)
            begin
              sck_q <= 1'b1;
              shift_q <= shift_next;
              bit_cnt_q <= bit_cnt_q + `SSTM_CNT_ONE;
              if (last_bit)
              begin
                start_q <= 1'b0;
                tail_cnt_q <= `SSTM_TAIL_ZERO;
                state_q <= tail_en ? ST_TAIL : ST_IDLE;
              end
            end
          end
          ST_TAIL:
          begin
            // Marker: data low with clock high, then data released high.
            if (half_tick)
            begin
              tail_cnt_q <= tail_cnt_q + `SSTM_TAIL_ONE;
              if (tail_cnt_q == `SSTM_TAIL_ZERO)
                so_q <= 1'b0;
              else if (tail_cnt_q == tail_len)
              begin
                so_q <= 1'b1;
                state_q <= ST_IDLE;
              end
            end
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control, flags and interrupt
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_q <= `SSTM_CTRL_RST;
      overrun_q <= 1'b0;
      ovr_seen_q <= 1'b0;
      done_req_q <= 1'b0;
      done_en_q <= 1'b0;
      pfun_q <= 3'h0;
      open_drain_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
        ctrl_q <= wdata_i;
      if (we_i && addr_i == `SSTM_OFS_IEN)
        done_en_q <= wdata_i[`SSTM_IEN_DONE];
      if (we_i && addr_i == `SSTM_OFS_PFUN)
        pfun_q <= wdata_i[2:0];
      if (we_i && addr_i == `SSTM_OFS_POUT)
        open_drain_q <= wdata_i[`SSTM_POUT_OD];
      // A new setting wins over a clear in the same cycle.
      if (word_done)
        done_req_q <= 1'b1;
      else if (wr_ireq && !wdata_i[`SSTM_IREQ_DONE])
        done_req_q <= 1'b0;
      if (rd_stat && overrun_q)
        ovr_seen_q <= 1'b1;
      if (ext_clk && idle && ext_rise && !ctrl_reset)
        overrun_q <= 1'b1;
      else if (wr_stat && !wdata_i[`SSTM_STAT_OVERRUN] && ovr_seen_q)
      begin
        overrun_q <= 1'b0;
        ovr_seen_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data and registered pin outputs
  // ----------------------------------------------------------------------
  reg [7:0] rd_mux;

  always @*
  begin
    case (addr_i)
      `SSTM_OFS_CTRL: rd_mux = ctrl_q;
      `SSTM_OFS_STAT: rd_mux = {1'b1, so_q, overrun_q, 3'h0,
        state_q == ST_TAIL, start_q};
      `SSTM_OFS_DLO: rd_mux = shift_q[7:0];
      `SSTM_OFS_DHI: rd_mux = shift_q[15:8];
      `SSTM_OFS_IREQ: rd_mux = {7'h00, done_req_q};
      `SSTM_OFS_IEN: rd_mux = {7'h00, done_en_q};
      `SSTM_OFS_PFUN: rd_mux = {5'h00, pfun_q};
      default: rd_mux = {7'h00, open_drain_q};
    endcase
  end

  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= `SSTM_BYTE_ZERO;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      sck_o <= 1'b1;
      sck_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata_o <= re_i ? rd_mux : `SSTM_BYTE_ZERO;
      // Open drain only pulls low; a high level is left to the pull-up.
      so_o <= open_drain_q ? 1'b0 : so_q;
      so_oe_o <= pfun_q[`SSTM_PFUN_SO] && (!open_drain_q || !so_q);
      sck_o <= sck_q;
      sck_oe_o <= pfun_q[`SSTM_PFUN_SCK] && !ext_clk;
      irq_o <= done_req_q && done_en_q;
    end
  end

endmodule // sstm_core

// File: sim/sstm_core_assertions.sv
// Checker for the tail-marker shifter, watching only the core ports.
// Assumes the host keeps one-cycle strobes on the register port.
`timescale 1ns/1ps
module sstm_core_chk (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // Register port and pins
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire we_i,
  input wire re_i,
  input wire [7:0] rdata_o,
  input wire so_o,
  input wire sck_o,
  input wire irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire st_rd = re_i && addr_i == 3'h1;
  // Remembers that software has seen overrun set since its last status write.
  logic st_rd_q = 1'b0;
  logic ovr_read_q = 1'b0;
  always @(posedge sys_clk_i)
  begin
    st_rd_q <= st_rd;
    if (!rstn_i || (we_i && addr_i == 3'h1))
      ovr_read_q <= 1'b0;
    else if (st_rd_q && rdata_o[5])
      ovr_read_q <= 1'b1;
  end
  sequence s_idle_quiet;
    st_rd && !we_i ##1 !rdata_o[0] && !rdata_o[1] && !we_i ##1 !we_i [*4];
  endsequence
  sequence s_ovr_seen;
    st_rd && !we_i ##1 rdata_o[5] && !we_i ##1 st_rd;
  endsequence
  sequence s_start_wr;
    we_i && addr_i == 3'h1 && wdata_i[0] ##2 st_rd;
  endsequence
  sequence s_ovr_wr;
    we_i && addr_i == 3'h1 && !wdata_i[5] && ovr_read_q ##2 st_rd;
  endsequence
  // ------------------------------
  // Properties
  // ------------------------------
  a_rdata_idle: assert property (!re_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read answer");
  a_status_fixed: assert property (st_rd |=> rdata_o[7] && rdata_o[4:2] == 3'b000)
    else $error("status fixed bits wrong");
  a_tail_flag: assert property (st_rd ##1 rdata_o[1] |-> !rdata_o[0])
    else $error("start still set while marker is sent");
  a_start_busy: assert property (s_start_wr |=> rdata_o[0])
    else $error("start flag not set after start write");
  a_clock_stopped: assert property (s_idle_quiet |-> sck_o && $stable(so_o))
    else $error("clock or data moved while idle");
  a_irq_masked: assert property (
    we_i && addr_i == 3'h5 && !wdata_i[0] ##1 !(we_i && addr_i == 3'h5) |=> !irq_o)
    else $error("interrupt raised while disabled");
  a_ovr_sticky: assert property (s_ovr_seen |=> rdata_o[5])
    else $error("overrun cleared without a write");
  a_ovr_clear: assert property (s_ovr_wr |=> !rdata_o[5])
    else $error("overrun not cleared by a zero write");
endmodule // sstm_core_chk

bind sstm_core sstm_core_chk sstm_core_chk_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
  .so_o(so_o), .sck_o(sck_o), .irq_o(irq_o));

// File: sim/sstm_peer.sv
// Behavioural serial peer on the far side of the shifter pins.
// Assumes the bench pulls the data pin up and hands the clock pin to sck_ext_o whenever the core does not drive it.
`timescale 1ns/1ps
module sstm_peer (
  // Clock and pins
  input wire logic sys_clk_i,
  input wire logic sck_pin_i,
  input wire logic so_pin_i,
  // Drives
  output logic si_o,
  output logic sck_ext_o
);
  logic [15:0] tx_q = 16'h0000;
  logic [15:0] rx_q = 16'h0000;
  int n_bits = 0;
  int width = 0;
  initial
  begin
    si_o = 1'b0;
    sck_ext_o = 1'b1;
  end
  task automatic load(input logic [15:0] tx, input int w);
    tx_q = tx;
    rx_q = 16'h0000;
    n_bits = 0;
    width = w;
  endtask
  // Outside a frame the line wanders, so a stale bit never passes for data.
  always @(posedge sys_clk_i)
    if (n_bits >= width) si_o <= ~si_o;
  always @(negedge sck_pin_i)
    if (n_bits < width) si_o <= tx_q[n_bits];
  always @(posedge sck_pin_i)
  begin
    if (n_bits < width)
    begin
      rx_q[n_bits] <= so_pin_i;
      n_bits <= n_bits + 1;
    end
  end
  task automatic clocks(input int n);
    repeat (n)
    begin
      repeat (8) @(posedge sys_clk_i);
      sck_ext_o <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      sck_ext_o <= 1'b1;
    end
  endtask
endmodule // sstm_peer

// File: sim/sstm_core_tb.sv
// Self-checking bench for the tail-marker shifter core.
// Assumes the peer model and the checker are compiled before it.
`timescale 1ns/1ps
module sstm_core_tb;
  logic clk, rstn, we, re, si, sck_ext, so, so_oe, sck, sck_oe, irq;
  logic re_d = 1'b0;
  logic ce = 1'b1;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [15:0] tx, pw, m;
  logic [15:0] q[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int len[3];
  wire so_pin = so_oe ? so : 1'b1;
  wire sck_pin = sck_oe ? sck : sck_ext;
  sstm_core sstm_core_i (.sys_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .addr_i(addr),
    .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .so_o(so), .so_oe_o(so_oe),
    .si_i(si), .sck_i(sck_pin), .sck_o(sck), .sck_oe_o(sck_oe), .irq_o(irq));
  sstm_peer sstm_peer_i (.sys_clk_i(clk), .sck_pin_i(sck_pin), .so_pin_i(so_pin),
    .si_o(si), .sck_ext_o(sck_ext));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop(input bit hung);
    if (hung) n_mismatch++;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // A zero mask notes a read whose value only steers the bench.
  task automatic rd(input logic [2:0] a, input logic [7:0] mk, input logic [7:0] e);
    q.push_back({mk, e});
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic idle();
    v = 8'h01;
    for (int i = 0; i < 6000 && v[0] !== 1'b0; i++) rd(3'h1, 8'h00, 8'h00);
    if (v[0] !== 1'b0) report_and_stop(1'b1);
  endtask
  always @(posedge clk) re_d <= re;
  always @(negedge clk)
  begin
    if (re_d && q.size() > 0)
    begin
      if (q[0][15:8] !== 8'h00) chk("rdata", {8'h00, q[0][7:0]}, {8'h00, rdata & q[0][15:8]});
      void'(q.pop_front());
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    rstn = 1'b0;
    we = 1'b0;
    re = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    void'($urandom(32'ha89e_e669));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(3'h1, 8'hff, 8'h80);
    rd(3'h0, 8'hff, 8'h00);
    wr(3'h6, 8'h07);
    for (int i = 0; i < 2; i++)
    begin
      tx = 16'($urandom);
      pw = 16'($urandom);
      m = i ? 16'hffff : 16'h00ff;
      wr(3'h0, i ? 8'h45 : 8'h05);
      wr(3'h5, i ? 8'h00 : 8'h01);
      wr(3'h3, tx[15:8]);
      wr(3'h2, tx[7:0]);
      sstm_peer_i.load(pw, 8 << i);
      wr(3'h1, 8'h01);
      rd(3'h1, 8'h83, 8'h81);
      idle();
      chk("peer rx", tx & m, sstm_peer_i.rx_q);
      chk("so hold", {15'h0000, tx[7 + 8 * i]}, {15'h0000, so});
      rd(3'h2, 8'hff, pw[7:0]);
      if (i) rd(3'h3, 8'hff, pw[15:8]);
      rd(3'h4, 8'h01, 8'h01);
      chk("irq", {15'h0000, i == 0}, {15'h0000, irq});
      wr(3'h4, 8'h00);
    end
    wr(3'h1, 8'h40);
    rd(3'h1, 8'hc3, 8'hc0);
    wr(3'h1, 8'h01);
    repeat (20) @(posedge clk);
    // A low enable must freeze the running transfer, pins included.
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    pw = {14'h0000, sck, so};
    repeat (40) @(posedge clk);
    chk("ce freeze", pw, {14'h0000, sck, so});
    ce <= 1'b1;
    wr(3'h0, 8'h05);
    rd(3'h1, 8'h03, 8'h00);
    wr(3'h0, 8'h08);
    tx = 16'($urandom);
    pw = 16'($urandom);
    wr(3'h2, tx[7:0]);
    sstm_peer_i.load(pw, 8);
    wr(3'h1, 8'h01);
    rd(3'h1, 8'h83, 8'h81);
    sstm_peer_i.clocks(8);
    idle();
    chk("ext rx", tx & 16'h00ff, sstm_peer_i.rx_q);
    sstm_peer_i.clocks(1);
    rd(3'h1, 8'h21, 8'h20);
    rd(3'h1, 8'h21, 8'h20);
    rd(3'h2, 8'hff, pw[7:0]);
    wr(3'h1, 8'h00);
    rd(3'h1, 8'h21, 8'h00);
    wr(3'h7, 8'h01);
    wr(3'h1, 8'h40);
    for (int k = 0; k < 3; k++)
    begin
      // Rates 1 and 0 keep the transfer clock period at two microseconds or more.
      wr(3'h0, {2'b00, 1'b1, k == 1, 1'b0, 2'b00, k != 2});
      wr(3'h2, 8'ha5);
      sstm_peer_i.load(16'h0000, 8);
      wr(3'h1, 8'h41);
      idle();
      rd(3'h1, 8'h83, 8'h82);
      chk("tail rx", 16'h00a5, sstm_peer_i.rx_q);
      for (int t = 0; t < 3000 && so_pin !== 1'b0; t++) @(posedge clk);
      if (so_pin !== 1'b0) report_and_stop(1'b1);
      len[k] = 0;
      while (so_pin === 1'b0 && len[k] < 3000)
      begin
        @(posedge clk);
        len[k]++;
      end
      if (len[k] >= 3000) report_and_stop(1'b1);
    end
    chk("latch len", 16'(len[0] * 2), 16'(len[1]));
    chk("rate len", 16'(len[0] * 4), 16'(len[2]));
    report_and_stop(1'b0);
  end
endmodule // sstm_core_tb
